/* File: design/peak_loc_pkg.sv */
// Package for the reflection peak location bank.
// Assumes a 32-bit AXI4-Lite register bus with word indexes at four bytes each.
package peak_loc_pkg;

  // ==========================================================================
  // Bank geometry
  localparam int POS_WIDTH = 8;
  localparam int PEAK_COUNT = 20;
  localparam int REG_WIDTH = 16;
  localparam int INDEX_WIDTH = 14;
  localparam int UPPER_LSB = 8;
  localparam int LOWER_LSB = 0;

  // ==========================================================================
  // Register indexes; byte address is four times the index
  localparam logic [INDEX_WIDTH-1:0] POS_A2_A1_INDEX = 14'h0190;
  localparam logic [INDEX_WIDTH-1:0] POS_A4_A3_INDEX = 14'h0191;
  localparam logic [INDEX_WIDTH-1:0] POS_B1_A5_INDEX = 14'h0192;
  localparam logic [INDEX_WIDTH-1:0] POS_B3_B2_INDEX = 14'h0193;
  localparam logic [INDEX_WIDTH-1:0] POS_B5_B4_INDEX = 14'h0194;
  localparam logic [INDEX_WIDTH-1:0] POS_C2_C1_INDEX = 14'h0195;
  localparam logic [INDEX_WIDTH-1:0] POS_C4_C3_INDEX = 14'h0196;
  localparam logic [INDEX_WIDTH-1:0] POS_D1_C5_INDEX = 14'h0197;
  localparam logic [INDEX_WIDTH-1:0] POS_D3_D2_INDEX = 14'h0198;
  localparam logic [INDEX_WIDTH-1:0] POS_D5_D4_INDEX = 14'h0199;
  localparam logic [INDEX_WIDTH-1:0] CAPTURE_CTRL_INDEX = 14'h01A0;
  localparam logic [INDEX_WIDTH-1:0] CAPTURE_STATUS_INDEX = 14'h01A1;

  // ==========================================================================
  // Field positions and reset values
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int STATUS_LOADED_BIT = 0;
  localparam int STATUS_COUNT_LSB = 8;
  localparam logic [PEAK_COUNT*POS_WIDTH-1:0] POS_RESET = '0;
  localparam logic CAPTURE_ENABLE_RESET = 1'b1;
  localparam logic [7:0] UPDATE_COUNT_RESET = 8'h00;

  // ==========================================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: design/reflect_peak_bank.sv */
// Read-only bank of cable reflection peak positions, five per pair A to D.
// Assumes the measurement engine pulses meas_done with all twenty positions
// on meas_pos, and a single AXI4-Lite master on the register side.
//
// Functional notes
// R1: 0x0191 holds A peak4 high, A peak3 low
// R2: 0x0192 holds B peak1 high, A peak5 low
// R3: 0x0193 holds B peak3 high, B peak2 low
// R4: 0x0194 holds B peak5 high, B peak4 low
// R5: 0x0195 holds C peak2 high, C peak1 low
// R6: 0x0196 holds C peak4 high, C peak3 low
// R7: 0x0197 holds D peak1 high, C peak5 low
// R8: 0x0198 holds D peak3 high, D peak2 low
// R9: 0x0199 holds D peak5 high, D peak4 low
// R10: Each byte is a peak distance from transceiver
// R11: Fields read-only, zero after reset
// R12: 0x0190 holds A peak2 high, A peak1 low
// R13: All fields update together on measurement completion
`timescale 1ns/1ps
module reflect_peak_bank
  import peak_loc_pkg::*;
(
  input wire logic aclk, // 100 MHz clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [15:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [15:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic meas_done, // One-cycle pulse: measurement finished
  input wire logic [PEAK_COUNT*POS_WIDTH-1:0] meas_pos // Byte k = channel*5 + peak-1
);

  // ==========================================================================
  // State
  logic [PEAK_COUNT*POS_WIDTH-1:0] pos, next_pos;
  logic capture_en, next_capture_en;
  logic result_loaded, next_result_loaded;
  logic [7:0] update_count, next_update_count;
  logic aw_got, next_aw_got;
  logic w_got, next_w_got;
  logic [INDEX_WIDTH-1:0] wr_index, next_wr_index;
  logic [31:0] wr_data, next_wr_data;
  logic [3:0] wr_strb, next_wr_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic load_now;
  logic clear_req;
  logic do_write;
  logic [INDEX_WIDTH-1:0] rd_index;
  logic [REG_WIDTH-1:0] rd_word;
  logic rd_hit;

  // Handshake outputs
  assign s_axi_awready = !aw_got && !bvalid;
  assign s_axi_wready = !w_got && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;

  // ==========================================================================
  // Result bank: one atomic load per finished measurement
  assign load_now = meas_done && capture_en; // R13
  assign do_write = aw_got && w_got && !bvalid;
  assign clear_req = do_write && (wr_index == CAPTURE_CTRL_INDEX) && wr_strb[0]
                     && wr_data[CTRL_CLEAR_BIT];

  always_comb begin
    next_pos = pos;
    next_result_loaded = result_loaded;
    next_update_count = update_count;
    if (clear_req) begin
      next_result_loaded = 1'b0;
    end
    if (load_now) begin
      next_pos = meas_pos; // R10 R13
      next_result_loaded = 1'b1; // Set wins over a clear in the same cycle
      next_update_count = update_count + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos <= POS_RESET; // R11
      result_loaded <= 1'b0;
      update_count <= UPDATE_COUNT_RESET;
    end else begin
      pos <= next_pos;
      result_loaded <= next_result_loaded;
      update_count <= next_update_count;
    end
  end

  // ==========================================================================
  // Write channel: address and data taken in either order
  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_wr_index = wr_index;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_capture_en = capture_en;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_wr_index = s_axi_awaddr[15:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_wr_data = s_axi_wdata;
      next_wr_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      if (wr_index == CAPTURE_CTRL_INDEX) begin
        next_bresp = RESP_OKAY;
        if (wr_strb[0]) begin
          next_capture_en = wr_data[CTRL_ENABLE_BIT];
        end
      end else if (wr_index >= POS_A2_A1_INDEX && wr_index <= POS_D5_D4_INDEX) begin
        next_bresp = RESP_OKAY; // R11
      end else if (wr_index == CAPTURE_STATUS_INDEX) begin
        next_bresp = RESP_OKAY;
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wr_index <= '0;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      capture_en <= CAPTURE_ENABLE_RESET;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      wr_index <= next_wr_index;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      capture_en <= next_capture_en;
    end
  end

  // ==========================================================================
  // Read decode: two positions per position word, upper byte is the later field
  assign rd_index = s_axi_araddr[15:2];

  always_comb begin
    rd_word = 16'h0000;
    rd_hit = 1'b1;
    unique case (rd_index)
      POS_A2_A1_INDEX: rd_word = pos[0*REG_WIDTH +: REG_WIDTH]; // R12
      POS_A4_A3_INDEX: rd_word = pos[1*REG_WIDTH +: REG_WIDTH]; // R1
      POS_B1_A5_INDEX: rd_word = pos[2*REG_WIDTH +: REG_WIDTH]; // R2
      POS_B3_B2_INDEX: rd_word = pos[3*REG_WIDTH +: REG_WIDTH]; // R3
      POS_B5_B4_INDEX: rd_word = pos[4*REG_WIDTH +: REG_WIDTH]; // R4
      POS_C2_C1_INDEX: rd_word = pos[5*REG_WIDTH +: REG_WIDTH]; // R5
      POS_C4_C3_INDEX: rd_word = pos[6*REG_WIDTH +: REG_WIDTH]; // R6
      POS_D1_C5_INDEX: rd_word = pos[7*REG_WIDTH +: REG_WIDTH]; // R7
      POS_D3_D2_INDEX: rd_word = pos[8*REG_WIDTH +: REG_WIDTH]; // R8
      POS_D5_D4_INDEX: rd_word = pos[9*REG_WIDTH +: REG_WIDTH]; // R9
      CAPTURE_CTRL_INDEX: rd_word = {15'h0000, capture_en};
      CAPTURE_STATUS_INDEX: rd_word = {update_count, 7'h00, result_loaded};
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel: answer one cycle after the address is taken
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = {16'h0000, rd_word};
      next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ==========================================================================
  // Assertions
  logic ar_take;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  a_pos_read_a21: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    ar_take && rd_index == POS_A2_A1_INDEX |=> rvalid
    && rdata == {16'h0000, $past(pos[15:8]), $past(pos[7:0])})
    else $error("Word 0x190 does not carry A peak 2 and 1");
  a_pos_read_a43: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    ar_take && rd_index == POS_A4_A3_INDEX |=> rdata[15:0] == $past(pos[31:16]))
    else $error("Word 0x191 does not carry A peak 4 and 3");
  a_pos_read_b1a5: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    ar_take && rd_index == POS_B1_A5_INDEX |=> rdata[7:0] == $past(pos[39:32])
    && rdata[15:8] == $past(pos[47:40]))
    else $error("Word 0x192 does not carry B peak 1 and A peak 5");
  a_pos_read_b32: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    ar_take && rd_index == POS_B3_B2_INDEX |=> rdata[15:0] == $past(pos[63:48]))
    else $error("Word 0x193 does not carry B peak 3 and 2");
  a_pos_read_b54: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    ar_take && rd_index == POS_B5_B4_INDEX |=> rdata[15:0] == $past(pos[79:64]))
    else $error("Word 0x194 does not carry B peak 5 and 4");
  a_pos_read_c21: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    ar_take && rd_index == POS_C2_C1_INDEX |=> rdata[15:0] == $past(pos[95:80]))
    else $error("Word 0x195 does not carry C peak 2 and 1");
  a_pos_read_c43: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    ar_take && rd_index == POS_C4_C3_INDEX |=> rdata[15:0] == $past(pos[111:96]))
    else $error("Word 0x196 does not carry C peak 4 and 3");
  a_pos_read_d1c5: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    ar_take && rd_index == POS_D1_C5_INDEX |=> rdata[15:0] == $past(pos[127:112]))
    else $error("Word 0x197 does not carry D peak 1 and C peak 5");
  a_pos_read_d32: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    ar_take && rd_index == POS_D3_D2_INDEX |=> rdata[15:0] == $past(pos[143:128]))
    else $error("Word 0x198 does not carry D peak 3 and 2");
  a_pos_read_d54: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    ar_take && rd_index == POS_D5_D4_INDEX |=> rdata[31:0] == {16'h0000, $past(pos[159:144])})
    else $error("Word 0x199 does not carry D peak 5 and 4");
  a_load_copies_input: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    meas_done && capture_en |=> pos == $past(meas_pos) && result_loaded)
    else $error("Finished measurement not loaded into bank");
  a_reset_clears_bank: assert property (@(posedge aclk) // R11
    !aresetn |=> pos == POS_RESET && update_count == UPDATE_COUNT_RESET)
    else $error("Bank not zero after reset");
  a_bank_holds_between: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    !(meas_done && capture_en) |=> $stable(pos))
    else $error("Bank changed without a finished measurement");
  a_write_leaves_bank: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    do_write && wr_index <= POS_D5_D4_INDEX && wr_index >= POS_A2_A1_INDEX && !meas_done
    |=> bvalid && bresp == RESP_OKAY && $stable(pos))
    else $error("Write to read-only word disturbed bank or response");

  // Upper half of every answer is zero; decode misses answer with an error
  a_read_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    rvalid |-> rdata[31:16] == 16'h0000)
    else $error("Read data upper half not zero");
  a_unmapped_read_err: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    ar_take && !rd_hit |=> rresp == RESP_SLVERR && rdata == 32'h00000000)
    else $error("Unmapped read not answered with error and zero");
  a_unmapped_write_err: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    do_write && (wr_index < POS_A2_A1_INDEX || wr_index > POS_D5_D4_INDEX)
    && wr_index != CAPTURE_CTRL_INDEX && wr_index != CAPTURE_STATUS_INDEX
    |=> bresp == RESP_SLVERR)
    else $error("Unmapped write not answered with error");
  a_ctrl_read_enable: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    ar_take && rd_index == CAPTURE_CTRL_INDEX |=> rdata == {31'h00000000, $past(capture_en)})
    else $error("Control word does not show the capture gate");

  // Capture gate, update counter and loaded flag
  a_count_per_load: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    load_now |=> update_count == $past(update_count) + 8'h01)
    else $error("Update count did not step on a load");
  a_gate_blocks_load: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    meas_done && !capture_en |=> $stable(pos) && $stable(update_count))
    else $error("Measurement landed while capture was disabled");
  a_clear_drops_flag: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    clear_req && !load_now |=> !result_loaded)
    else $error("Clear request left the loaded flag set");
  a_reset_flags: assert property (@(posedge aclk) // R11
    !aresetn |=> !result_loaded && capture_en)
    else $error("Loaded flag or capture gate wrong after reset");

endmodule

/* File: verif/cable_reflection_peak_locations_test.sv */
// Self-checking bench for the reflection peak location bank.
// Assumes the bench alone drives the register bus and the measurement port.
`timescale 1ns/1ps
module cable_reflection_peak_locations_test
  import peak_loc_pkg::*;
;
  // ==========================================================================
  // Signals and reference model
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, meas_done;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [PEAK_COUNT*POS_WIDTH-1:0] meas_pos;
  int mdl_pos [PEAK_COUNT];
  int mdl_en, mdl_loaded, mdl_count;
  int err_count = 0;
  int checks = 0;
  integer seed = 32'h0AE6A507;

  // Free-running 100 MHz clock
  always #5 aclk = ~aclk;

  reflect_peak_bank i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .meas_done(meas_done), .meas_pos(meas_pos)
  );

  // ==========================================================================
  // Comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // Bus master; handshakes are judged on the values held just before each edge
  task automatic axi_write(input logic [15:0] addr, input logic [31:0] data,
      input logic [1:0] exp_resp);
    logic aw_hs, w_hs, b_hs, done;
    logic [1:0] resp;
    @(posedge aclk);
    s_axi_awaddr <= addr;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= data;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid && s_axi_bready;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      if (b_hs) begin
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    check({30'h0, resp}, {30'h0, exp_resp});
  endtask

  task automatic axi_read(input logic [15:0] addr, output logic [31:0] data,
      output logic [1:0] resp);
    logic ar_hs, r_hs, done;
    @(posedge aclk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid && s_axi_rready;
      data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      if (r_hs) begin
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // ==========================================================================
  // Scenario helpers
  task automatic check_bank();
    logic [31:0] data, exp;
    logic [1:0] resp;
    for (int i = 0; i < 10; i++) begin
      axi_read({POS_A2_A1_INDEX + 14'(i), 2'b00}, data, resp);
      exp = 32'(mdl_pos[2*i] + 256 * mdl_pos[2*i+1]);
      check(data, exp);
      check({30'h0, resp}, {30'h0, RESP_OKAY});
    end
  endtask

  task automatic check_status();
    logic [31:0] data;
    logic [1:0] resp;
    axi_read({CAPTURE_STATUS_INDEX, 2'b00}, data, resp);
    check(data, 32'((mdl_count % 256) * 256 + mdl_loaded));
    axi_read({CAPTURE_CTRL_INDEX, 2'b00}, data, resp);
    check(data, 32'(mdl_en));
  endtask

  // Back-to-back pulses when n > 1; data changes while idle must not land
  task automatic measure(input int n);
    logic [PEAK_COUNT*POS_WIDTH-1:0] v;
    @(posedge aclk);
    for (int j = 0; j < n; j++) begin
      for (int k = 0; k < PEAK_COUNT; k++) begin
        v[8*k +: 8] = 8'($random(seed));
        if (mdl_en != 0) mdl_pos[k] = int'(v[8*k +: 8]);
      end
      if (mdl_en != 0) mdl_count++;
      if (mdl_en != 0) mdl_loaded = 1;
      meas_pos <= v;
      meas_done <= 1'b1;
      @(posedge aclk);
    end
    meas_done <= 1'b0;
    meas_pos <= ~v;
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < PEAK_COUNT; k++) mdl_pos[k] = 0;
    mdl_en = 1;
    mdl_loaded = 0;
    mdl_count = 0;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic [13:0] bad [2];
    logic [31:0] data;
    logic [1:0] resp;
    bad[0] = 14'h018F;
    bad[1] = 14'h019A;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 4'h0;
    {s_axi_arvalid, s_axi_rready, meas_done} <= 3'h0;
    s_axi_awaddr <= 16'h0000;
    s_axi_araddr <= 16'h0000;
    s_axi_wdata <= 32'h00000000;
    s_axi_wstrb <= 4'hF;
    meas_pos <= '0;
    do_reset();
    check_bank();
    check_status();
    measure(1);
    check_bank();
    check_status();
    for (int i = 0; i < 10; i++) axi_write({POS_A2_A1_INDEX + 14'(i), 2'b00}, $random(seed),
        RESP_OKAY);
    check_bank();
    for (int i = 0; i < 2; i++) begin
      axi_write({bad[i], 2'b00}, 32'hFFFFFFFF, RESP_SLVERR);
      axi_read({bad[i], 2'b00}, data, resp);
      check(data, 32'h00000000);
      check({30'h0, resp}, {30'h0, RESP_SLVERR});
    end
    axi_write({CAPTURE_CTRL_INDEX, 2'b00}, 32'h00000000, RESP_OKAY);
    mdl_en = 0;
    measure(2);
    check_bank();
    check_status();
    s_axi_wstrb <= 4'hE;
    axi_write({CAPTURE_CTRL_INDEX, 2'b00}, 32'h00000001, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    check_status();
    axi_write({CAPTURE_CTRL_INDEX, 2'b00}, 32'h00000003, RESP_OKAY);
    mdl_en = 1;
    mdl_loaded = 0;
    check_status();
    measure(3);
    check_bank();
    check_status();
    repeat (4) begin
      measure(1);
      check_bank();
    end
    axi_write({CAPTURE_CTRL_INDEX, 2'b00}, 32'h00000000, RESP_OKAY);
    do_reset();
    check_bank();
    check_status();
    print_verdict();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    print_verdict();
  end
endmodule
